// >>> ir_adc_pkg.sv
package ir_adc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_RECOVERY = 8'h1d;
    localparam logic [7:0] IDX_SCALE = 8'h1e;
    localparam logic [7:0] IDX_RANGE = 8'h1f;
    localparam logic [7:0] IDX_STATUS = 8'h20;
    localparam logic [7:0] ADDR_RECOVERY = {IDX_RECOVERY[5:0], 2'b00};
    localparam logic [7:0] ADDR_SCALE = {IDX_SCALE[5:0], 2'b00};
    localparam logic [7:0] ADDR_RANGE = {IDX_RANGE[5:0], 2'b00};
    localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'b00};
    // field layout
    localparam int SCALE_LSB = 0;
    localparam int SCALE_W = 3;
    localparam int RANGE_BIT = 5;
    localparam int RESV_W = 5;
    localparam int RECOVERY_LSB = 4;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_FEAT_BIT = 1;
    localparam int STATUS_LOWPWR_BIT = 2;
    // reset values
    localparam logic [2:0] SCALE_RST = 3'h0;
    localparam logic RANGE_RST = 1'b0;
    localparam logic [4:0] RESV_RST = 5'h00;
    localparam logic [2:0] RECOVERY_RST = 3'h7;
    // largest division factor, reached at scale code 7
    localparam int MAX_FACTOR = 128;
    // high range cuts gain by this figure divided by ten
    localparam int HIGH_RANGE_GAIN_CUT_X10 = 145;
    // arbitrary neutral value, not tied to any real sequencer
    localparam logic [7:0] MIN_SEQ_REV_DEFAULT = 8'h10;
    localparam logic [9:0] CONV_TICKS_DEFAULT = 10'h040;
    // cycles after reset release before the pin level is caught
    localparam logic [1:0] POWERUP_SETTLE = 2'h3;
    typedef enum logic [1:0] {ST_IDLE, ST_RECOVER, ST_CONVERT} conv_state_type;
endpackage

// >>> ir_adc_ctrl.sv
`timescale 1ns/100ps

// Function
// [R1] ADC clock for IR ambient divided by two to the 3-bit scale, max 128.
// [R2] Scale 0 undivided, 4 divides by 16, 6 divides by 64.
// [R3] Bit 5 of range control selects high range, gain cut by 14.5.
// [R4] Host preserves reserved bits 4:0 by read-modify-write.
// [R5] Interrupt line held high during power-up enables low-power operation.
// [R6] Scale and range honoured only at or above minimum sequencer revision.
// [R7] Host programs recovery period as inverse of scale value.
// [R8] New scale or range applies at next conversion start, never midway.
module ir_adc_ctrl
    import ir_adc_pkg::*;
#(
    parameter logic [7:0] MIN_SEQ_REV = MIN_SEQ_REV_DEFAULT,
    parameter logic [9:0] CONV_TICKS = CONV_TICKS_DEFAULT
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sequencer side
    input wire logic [7:0] seq_revision,
    input wire logic conv_start,
    output logic adc_clk_en,
    output logic conv_busy,
    output logic conv_done,
    output logic [2:0] scale_active,
    output logic high_range_active,
    output logic low_power_en,
    // open-drain interrupt pin
    input wire logic int_in,
    output logic int_out,
    output logic int_oe_n
);
    // register state
    logic [2:0] scale_q;
    logic range_q;
    logic [4:0] resv_q;
    logic [2:0] recovery_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    // conversion state
    conv_state_type state_q;
    logic [6:0] div_cnt_q;
    logic [9:0] tick_cnt_q;
    logic [2:0] scale_act_q;
    logic range_act_q;
    logic [2:0] rec_act_q;
    logic tick_q;
    logic done_q;
    logic busy_q;
    // pin and power-up
    logic int_s1_q, int_s2_q, int_s3_q;
    logic [1:0] pu_cnt_q;
    logic pu_done_q;
    logic low_power_q;

    // bus decode
    wire access = psel && penable;
    wire bus_ready = access && pready_q;
    wire bus_wr = bus_ready && pwrite;
    wire sel_rec = (paddr == ADDR_RECOVERY);
    wire sel_scale = (paddr == ADDR_SCALE);
    wire sel_range = (paddr == ADDR_RANGE);
    wire sel_status = (paddr == ADDR_STATUS);
    wire mapped = sel_rec || sel_scale || sel_range || sel_status;
    wire feat_ok = (seq_revision >= MIN_SEQ_REV);
    wire busy = (state_q != ST_IDLE);

    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (sel_rec)
            rd_mux[RECOVERY_LSB +: 3] = recovery_q;
        else if (sel_scale)
            rd_mux[SCALE_LSB +: SCALE_W] = scale_q;
        else if (sel_range)
        begin
            rd_mux[RANGE_BIT] = range_q;
            rd_mux[RESV_W-1:0] = resv_q; // R4
        end
        else if (sel_status)
        begin
            rd_mux[STATUS_BUSY_BIT] = busy;
            rd_mux[STATUS_FEAT_BIT] = feat_ok;
            rd_mux[STATUS_LOWPWR_BIT] = low_power_q;
        end
    end

    // one wait state per access keeps every bus output registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= access && !pready_q;
            prdata_q <= (access && !pready_q && !pwrite) ? rd_mux : 32'h0000_0000;
            pslverr_q <= access && !pready_q && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scale_q <= SCALE_RST;
            range_q <= RANGE_RST;
            resv_q <= RESV_RST;
            recovery_q <= RECOVERY_RST;
        end
        else if (bus_wr)
        begin
            if (sel_rec)
                recovery_q <= pwdata[RECOVERY_LSB +: 3];
            if (sel_scale)
                scale_q <= pwdata[SCALE_LSB +: SCALE_W];
            if (sel_range)
            begin
                range_q <= pwdata[RANGE_BIT];
                // stored as written so a read-modify-write returns it intact
                resv_q <= pwdata[RESV_W-1:0]; // R4
            end
        end
    end

    // adc clock prescaler: one tick every 2^scale cycles
    wire [7:0] factor = 8'h01 << scale_act_q; // R1
    wire [6:0] div_top = 7'(factor - 8'h01); // R2
    wire div_last = busy && (div_cnt_q == div_top);
    // recovery length in adc ticks: 1, then 2^(code+2)-1
    wire [10:0] rec_pow = 11'h001 << ({1'b0, rec_act_q} + 4'h2);
    wire [9:0] rec_ticks = (rec_act_q == 3'h0) ? 10'h001 : 10'(rec_pow - 11'h001);
    wire rec_end = div_last && (tick_cnt_q == rec_ticks - 10'h001);
    wire conv_end = div_last && (tick_cnt_q == CONV_TICKS - 10'h001);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_cnt_q <= 7'h00;
        else if (!busy || div_last)
            div_cnt_q <= 7'h00;
        else
            div_cnt_q <= div_cnt_q + 7'h01;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_IDLE;
            tick_cnt_q <= 10'h000;
            scale_act_q <= SCALE_RST;
            range_act_q <= RANGE_RST;
            rec_act_q <= RECOVERY_RST;
            done_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    tick_cnt_q <= 10'h000;
                    if (conv_start)
                    begin
                        // settings latched only here, held for the whole conversion
                        scale_act_q <= feat_ok ? scale_q : SCALE_RST; // R8 R6
                        range_act_q <= feat_ok ? range_q : RANGE_RST; // R3 R6
                        rec_act_q <= feat_ok ? recovery_q : 3'h0; // R6
                        busy_q <= 1'b1;
                        state_q <= ST_RECOVER;
                    end
                end
                ST_RECOVER:
                begin
                    if (rec_end)
                    begin
                        tick_cnt_q <= 10'h000;
                        state_q <= ST_CONVERT;
                    end
                    else if (div_last)
                        tick_cnt_q <= tick_cnt_q + 10'h001;
                end
                ST_CONVERT:
                begin
                    if (conv_end)
                    begin
                        done_q <= 1'b1;
                        busy_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                    else if (div_last)
                        tick_cnt_q <= tick_cnt_q + 10'h001;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_q <= 1'b0;
        else
            tick_q <= div_last; // R1
    end

    // pin sync and power-up level capture; the device never pulls the pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_s1_q <= 1'b0;
            int_s2_q <= 1'b0;
            int_s3_q <= 1'b0;
            pu_cnt_q <= 2'h0;
            pu_done_q <= 1'b0;
            low_power_q <= 1'b0;
        end
        else
        begin
            int_s1_q <= int_in;
            int_s2_q <= int_s1_q;
            int_s3_q <= int_s2_q;
            if (pu_cnt_q != POWERUP_SETTLE)
                pu_cnt_q <= pu_cnt_q + 2'h1;
            else if (!pu_done_q && (int_s2_q == int_s3_q))
            begin
                pu_done_q <= 1'b1;
                low_power_q <= int_s3_q; // R5
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign adc_clk_en = tick_q;
    assign conv_busy = busy_q;
    assign conv_done = done_q;
    assign scale_active = scale_act_q;
    assign high_range_active = range_act_q;
    assign low_power_en = low_power_q;
    assign int_out = 1'b0;
    assign int_oe_n = 1'b1;

    // helper: cycles since last adc tick within one conversion
    logic [7:0] gap_q;
    logic seen_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gap_q <= 8'h00;
            seen_q <= 1'b0;
        end
        else if (!busy)
        begin
            gap_q <= 8'h00;
            seen_q <= 1'b0;
        end
        else
        begin
            gap_q <= tick_q ? 8'h01 : gap_q + 8'h01;
            seen_q <= seen_q || tick_q;
        end
    end

    property p_tick_spacing;
        @(posedge pclk) disable iff (!presetn)
        (tick_q && seen_q && busy) |-> (gap_q == factor);
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("adc tick spacing wrong"); // R1
    property p_max_factor;
        @(posedge pclk) disable iff (!presetn)
        (tick_q && seen_q && busy && scale_act_q == 3'h7) |-> (gap_q == 8'(MAX_FACTOR));
    endproperty
    a_max_factor: assert property (p_max_factor) else $error("scale 7 not divide by 128"); // R1
    property p_div16;
        @(posedge pclk) disable iff (!presetn)
        (tick_q && seen_q && busy && scale_act_q == 3'h4) |-> (gap_q == 8'h10);
    endproperty
    a_div16: assert property (p_div16) else $error("scale 4 not divide by 16"); // R2
    property p_undivided;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_CONVERT && scale_act_q == 3'h0 && !conv_end) |=> tick_q;
    endproperty
    a_undivided: assert property (p_undivided) else $error("scale 0 not undivided"); // R2
    property p_range_latch;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_IDLE && conv_start && feat_ok) |=> (high_range_active == $past(range_q));
    endproperty
    a_range_latch: assert property (p_range_latch) else $error("range not taken at start"); // R3

    property p_old_seq;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_IDLE && conv_start && !feat_ok)
            |=> (scale_active == 3'h0 && !high_range_active);
    endproperty
    a_old_seq: assert property (p_old_seq) else $error("settings honoured on old sequencer"); // R6

    property p_hold_settings;
        @(posedge pclk) disable iff (!presetn)
        (busy && $past(busy)) |-> ($stable(scale_act_q) && $stable(range_act_q));
    endproperty
    a_hold_settings: assert property (p_hold_settings) else $error("settings changed midway"); // R8

    property p_done_idle;
        @(posedge pclk) disable iff (!presetn)
        conv_done |-> (state_q == ST_IDLE) ##1 !conv_done;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("done not a single idle pulse"); // R8

    c_high_range: cover property (@(posedge pclk) disable iff (!presetn)
        conv_done && high_range_active);
    c_max_scale: cover property (@(posedge pclk) disable iff (!presetn)
        conv_done && scale_active == 3'h7);
    c_restart: cover property (@(posedge pclk) disable iff (!presetn)
        conv_done ##1 (conv_start && state_q == ST_IDLE));
endmodule

// >>> int_pin_model.sv
`timescale 1ns/100ps
module int_pin_model
(
    // pin drivers
    input wire logic int_out,
    input wire logic int_oe_n,
    input wire logic hold_low,
    // resolved pin
    output logic int_level
);
    // board pull-up keeps the pin high unless someone sinks it
    assign int_level = ((!int_oe_n && !int_out) || hold_low) ? 1'b0 : 1'b1;
endmodule

// >>> ir_adc_ctrl_tb.sv
`timescale 1ns/100ps
module ir_adc_ctrl_tb;
    import ir_adc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0] paddr, seq_revision;
    logic [31:0] pwdata, prdata, rdat, rng;
    logic conv_start, adc_clk_en, conv_busy, conv_done, high_range_active;
    logic low_power_en, int_level, int_out, int_oe_n, hold_low;
    logic [2:0] scale_active;
    logic [2:0] codes [4] = '{3'h0, 3'h4, 3'h6, 3'h7};
    int err_count, compares, n;
    ir_adc_ctrl #(.CONV_TICKS(10'h004)) i_dut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .seq_revision(seq_revision),
        .conv_start(conv_start), .adc_clk_en(adc_clk_en), .conv_busy(conv_busy),
        .conv_done(conv_done), .scale_active(scale_active),
        .high_range_active(high_range_active), .low_power_en(low_power_en),
        .int_in(int_level), .int_out(int_out), .int_oe_n(int_oe_n));
    int_pin_model i_pin (.int_out(int_out), .int_oe_n(int_oe_n), .hold_low(hold_low),
        .int_level(int_level));
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask
    // called just after a rising edge; one idle cycle follows every transfer
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20)
        begin
            @(posedge pclk);
            k++;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
        begin
            $display("Error pready expected 1 seen timeout");
            err_count++;
            give_verdict();
        end
        @(posedge pclk);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, exp, rdat);
        check("pslverr", 32'h0, {31'h0, rerr});
    endtask
    // done_sel high waits for conv_done, low for an adc clock tick
    task automatic wait_for(input logic done_sel);
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while ((done_sel ? conv_done : adc_clk_en) !== 1'b1 && n < 40000);
        if (n >= 40000)
        begin
            $display("Error event expected 1 seen timeout");
            err_count++;
            give_verdict();
        end
    endtask
    task automatic start_conv();
        conv_start <= 1'b1;
        @(posedge pclk);
        conv_start <= 1'b0;
        @(posedge pclk);
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, conv_start, hold_low} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        seq_revision = 8'h10;
        err_count = 0;
        compares = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        rd_chk("recovery", ADDR_RECOVERY, 32'h70);
        rd_chk("scale", ADDR_SCALE, 32'h0);
        rd_chk("range", ADDR_RANGE, 32'h0);
        rd_chk("status", ADDR_STATUS, 32'h6);
        check("low_power_en", 32'h1, {31'h0, low_power_en});
        check("int_oe_n", 32'h1, {31'h0, int_oe_n});
        check("int_out", 32'h0, {31'h0, int_out});
        apb(1'b1, 8'h00, 32'hff);
        check("unmapped err", 32'h1, {31'h0, rerr});
        apb(1'b1, ADDR_SCALE, 32'hff);
        rd_chk("scale mask", ADDR_SCALE, 32'h7);
        apb(1'b1, ADDR_RANGE, 32'hff);
        rd_chk("range mask", ADDR_RANGE, 32'h3f);
        $display("test registers done");
        rng = 32'h0a;
        apb(1'b1, ADDR_RANGE, rng);
        apb(1'b1, ADDR_SCALE, {29'h0, codes[0]});
        apb(1'b1, ADDR_RECOVERY, {25'h0, ~codes[0], 4'h0});
        for (int i = 0; i < 4; i++)
        begin
            start_conv();
            check("conv_busy", 32'h1, {31'h0, conv_busy});
            check("scale_active", {29'h0, codes[i]}, {29'h0, scale_active});
            check("high_range", {31'h0, rng[5]}, {31'h0, high_range_active});
            wait_for(1'b0);
            wait_for(1'b0);
            check("tick spacing", 32'h1 << codes[i], n);
            apb(1'b0, ADDR_RANGE, 32'h0);
            apb(1'b1, ADDR_RANGE, rdat ^ 32'h20);
            apb(1'b1, ADDR_SCALE, {29'h0, codes[(i + 1) % 4]});
            apb(1'b1, ADDR_RECOVERY, {25'h0, ~codes[(i + 1) % 4], 4'h0});
            rd_chk("status busy", ADDR_STATUS, 32'h7);
            wait_for(1'b1);
            check("conv_busy end", 32'h0, {31'h0, conv_busy});
            check("scale held", {29'h0, codes[i]}, {29'h0, scale_active});
            check("range held", {31'h0, rng[5]}, {31'h0, high_range_active});
            rng = rng ^ 32'h20;
            @(posedge pclk);
        end
        rd_chk("reserved kept", ADDR_RANGE, rng);
        $display("test conversions done");
        seq_revision <= 8'h0f;
        apb(1'b1, ADDR_SCALE, 32'h5);
        apb(1'b1, ADDR_RANGE, 32'h20);
        start_conv();
        check("gated scale", 32'h0, {29'h0, scale_active});
        check("gated range", 32'h0, {31'h0, high_range_active});
        wait_for(1'b1);
        @(posedge pclk);
        rd_chk("status gated", ADDR_STATUS, 32'h4);
        seq_revision <= 8'h10;
        $display("test revision done");
        hold_low <= 1'b1;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        check("low_power_en low", 32'h0, {31'h0, low_power_en});
        rd_chk("status pin low", ADDR_STATUS, 32'h2);
        hold_low <= 1'b0;
        $display("test power-up pin done");
        give_verdict();
    end
endmodule
